//--- common/nvh_pkg.sv
// package: constants and carrier types for the nvsram host port controller
package nvh_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int RTC_REGS = 16;
  // clock register map sits at the top 16 bytes of the address space
  localparam logic [16:0] RTC_BASE = 17'h1FFF0;
  // strobe phase lengths in ns, rounded up to i_clk cycles (100 ns each)
  localparam int T_SETUP_NS = 100;
  localparam int T_STROBE_NS = 200;
  localparam int T_HOLD_NS = 100;
  localparam int CLK_NS = 100;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic wr;
    logic rtc;
    logic [16:0] addr;
    logic [7:0] wdata;
  } nvh_req_t;

  typedef struct packed {
    logic chip_on_n;
    logic write_n;
    logic out_drive_n;
    logic [16:0] addr;
  } nvh_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_SAVE = 3'b100
  } nvh_state_t;
endpackage

//--- hdl/nvh_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nvh_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb
  begin
    nxt_meta = i_d;
    nxt_q = meta_ff;
  end

  // reset to all ones, the idle level of the save-busy pin; the interrupt and data pins need not idle high
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= '1;
      q_ff <= '1;
    end
    else
    begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign o_q = q_ff;
endmodule // nvh_sync

//--- hdl/nvh_host.sv
// host controller driving the nvsram with clock over its parallel pins
`timescale 1ns/1ps
// Functional notes
// R1: 17 address lines select array or clock
// R2: single bidirectional 8-bit data bus
// R3: chip-on low selects; high ignores bus
// R4: write stores byte at addressed location
// R5: output drivers only while output drive low
// R6: output drive high floats the data bus
// R7: save-busy low while save in progress
// R8: pulling save-busy low starts a save
// R9: automatic save on power loss
// R10: automatic restore on power-up
// R11: software save or restore also supported
// R12: interrupt from alarm, watchdog, power monitor
// R13: interrupt polarity high push-pull or low open-drain
// R14: alarm once or periodic
// R15: calendar tracks leap years
// R16: 32.768 kHz crystal timebase
// R17: host waits while save-busy is low
module nvh_host
  import nvh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire nvh_pkg::nvh_req_t i_req,
  input wire logic i_save_req,
  input wire logic i_int_active_high,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_busy_seen,
  output logic o_int_seen,
  output nvh_pkg::nvh_bus_t o_bus,
  output logic [7:0] o_byte_bus_out,
  output logic o_byte_bus_oe_n,
  input wire logic [7:0] i_byte_bus_in,
  output logic o_nv_save_busy_n_out,
  output logic o_nv_save_busy_n_oe_n,
  input wire logic i_nv_save_busy_n_in,
  input wire logic i_int_pin
);
  import nvh_pkg::*;

  function automatic logic [16:0] map_addr(input nvh_req_t r);
    map_addr = r.rtc ? (RTC_BASE | {13'h0, r.addr[3:0]}) : r.addr;
  endfunction

  logic [9:0] sync_d;
  logic [9:0] sync_q;
  logic [7:0] rd_pin;
  logic busy_n_s;
  logic int_s;

  assign sync_d = {i_int_pin, i_nv_save_busy_n_in, i_byte_bus_in};

  nvh_sync #(.W(10)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_d(sync_d),
    .o_q(sync_q)
  );

  assign rd_pin = sync_q[7:0];
  assign busy_n_s = sync_q[8];
  assign int_s = sync_q[9];

  nvh_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  nvh_req_t req_ff, nxt_req;
  nvh_bus_t bus_ff, nxt_bus;
  logic [7:0] dout_ff, nxt_dout;
  logic doe_n_ff, nxt_doe_n;
  logic hsb_oe_n_ff, nxt_hsb_oe_n;
  logic ready_ff, nxt_ready;
  logic rdv_ff, nxt_rdv;
  logic [7:0] rdat_ff, nxt_rdat;
  logic busy_ff, nxt_busy;
  logic intf_ff, nxt_intf;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_req = req_ff;
    nxt_bus = bus_ff;
    nxt_dout = dout_ff;
    nxt_doe_n = doe_n_ff;
    nxt_hsb_oe_n = hsb_oe_n_ff;
    nxt_ready = 1'b0;
    nxt_rdv = 1'b0;
    nxt_rdat = rdat_ff;
    nxt_busy = ~busy_n_s; // R7
    nxt_intf = i_int_active_high ? int_s : ~int_s; // R13
    case (state_ff)
      ST_IDLE:
      begin
        // a request is taken only while the device is not saving
        if (i_save_req)
        begin
          nxt_hsb_oe_n = 1'b0; // R8
          nxt_cnt = STROBE_CYC;
          nxt_state = ST_SAVE;
        end
        else if (i_req_valid && busy_n_s) // R17
        begin
          // software save or restore sequences leave as plain accesses
          nxt_req = i_req; // R11
          nxt_bus.addr = map_addr(i_req); // R1
          nxt_dout = i_req.wdata;
          nxt_doe_n = ~i_req.wr; // R2
          nxt_cnt = SETUP_CYC;
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (cnt_ff <= 4'h1)
        begin
          nxt_bus.chip_on_n = 1'b0; // R3
          nxt_bus.write_n = ~req_ff.wr; // R4
          nxt_bus.out_drive_n = req_ff.wr; // R5
          nxt_cnt = STROBE_CYC;
          nxt_state = ST_STROBE;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_STROBE:
      begin
        if (cnt_ff <= 4'h1)
        begin
          nxt_bus.chip_on_n = 1'b1;
          nxt_bus.write_n = 1'b1;
          nxt_bus.out_drive_n = 1'b1; // R6
          nxt_cnt = HOLD_CYC;
          nxt_state = ST_HOLD;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_HOLD:
      begin
        // pins reach rd_pin two edges late: the byte driven during the
        // strobe is only seen at the first hold edge
        if (!req_ff.wr && cnt_ff == HOLD_CYC)
          nxt_rdat = rd_pin; // R5
        if (cnt_ff <= 4'h1)
        begin
          nxt_doe_n = 1'b1;
          nxt_rdv = ~req_ff.wr;
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end
        else
          nxt_cnt = cnt_ff - 4'h1;
      end
      ST_SAVE:
      begin
        // release the pin after a pulse and return to idle, where requests wait for busy to end
        if (cnt_ff != 4'h0)
          nxt_cnt = cnt_ff - 4'h1;
        else
        begin
          nxt_hsb_oe_n = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      req_ff <= '0;
      bus_ff <= '{chip_on_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1,
                  addr: 17'h00000};
      dout_ff <= 8'h00;
      doe_n_ff <= 1'b1;
      hsb_oe_n_ff <= 1'b1;
      ready_ff <= 1'b0;
      rdv_ff <= 1'b0;
      rdat_ff <= 8'h00;
      busy_ff <= 1'b0;
      intf_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      req_ff <= nxt_req;
      bus_ff <= nxt_bus;
      dout_ff <= nxt_dout;
      doe_n_ff <= nxt_doe_n;
      hsb_oe_n_ff <= nxt_hsb_oe_n;
      ready_ff <= nxt_ready;
      rdv_ff <= nxt_rdv;
      rdat_ff <= nxt_rdat;
      busy_ff <= nxt_busy;
      intf_ff <= nxt_intf;
    end
  end

  assign o_req_ready = ready_ff;
  assign o_rd_valid = rdv_ff;
  assign o_rd_data = rdat_ff;
  assign o_busy_seen = busy_ff;
  assign o_int_seen = intf_ff;
  assign o_bus = bus_ff;
  assign o_byte_bus_out = dout_ff;
  assign o_byte_bus_oe_n = doe_n_ff;
  assign o_nv_save_busy_n_out = 1'b0;
  assign o_nv_save_busy_n_oe_n = hsb_oe_n_ff;

  strobe_excl_a: assert property (@(posedge i_clk) // R5
    disable iff (i_sys_rst)
    !(bus_ff.write_n == 1'b0 && bus_ff.out_drive_n == 1'b0))
    else $error("write and output drive low together");
  drive_on_read_a: assert property (@(posedge i_clk) // R6
    disable iff (i_sys_rst)
    !(bus_ff.out_drive_n == 1'b0 && doe_n_ff == 1'b0))
    else $error("host drives bus during device read");
  select_pair_a: assert property (@(posedge i_clk) // R3
    disable iff (i_sys_rst)
    (bus_ff.chip_on_n == 1'b1) |-> (bus_ff.write_n && bus_ff.out_drive_n))
    else $error("strobe active without chip-on");
  no_busy_start_a: assert property (@(posedge i_clk) // R17
    disable iff (i_sys_rst)
    (state_ff == ST_IDLE && !busy_n_s && !i_save_req)
      |=> state_ff == ST_IDLE)
    else $error("access started while save busy");
  write_data_a: assert property (@(posedge i_clk) // R4
    disable iff (i_sys_rst)
    $fell(bus_ff.write_n) |-> !doe_n_ff && dout_ff == req_ff.wdata)
    else $error("write strobe without data driven");
  strobe_len_a: assert property (@(posedge i_clk) // R3
    disable iff (i_sys_rst)
    $fell(bus_ff.chip_on_n) |-> !bus_ff.chip_on_n [*2] ##1 bus_ff.chip_on_n)
    else $error("chip-on pulse length wrong");
  save_pulse_a: assert property (@(posedge i_clk) // R8
    disable iff (i_sys_rst)
    $fell(hsb_oe_n_ff) |-> !hsb_oe_n_ff [*3] ##1 hsb_oe_n_ff)
    else $error("save request pulse length wrong");
  addr_map_a: assert property (@(posedge i_clk) // R1
    disable iff (i_sys_rst)
    (!bus_ff.chip_on_n && req_ff.rtc) |-> bus_ff.addr[16:4] == 13'h1FFF)
    else $error("clock register address outside map");
  read_done_a: assert property (@(posedge i_clk) // R2
    disable iff (i_sys_rst)
    ($rose(bus_ff.out_drive_n) && !req_ff.wr) |=> rdv_ff)
    else $error("read result not returned after hold");
endmodule // nvh_host

//--- dv/nvh_dev_model.sv
// behavioural model of the nvsram with clock, seen from its pins
`timescale 1ns/1ps
module nvh_dev_model
  import nvh_pkg::*;
(
  input wire logic i_clk,
  input wire nvh_pkg::nvh_bus_t i_bus,
  input wire logic [7:0] i_byte_bus,
  input wire logic i_save_busy_n,
  input wire logic i_fire,
  input wire logic i_act_high,
  output logic [7:0] o_dq,
  output logic o_dq_drv,
  output logic o_busy_low,
  output logic o_int
);
  // only the low address byte is kept, enough for the scenarios
  logic [7:0] mem [0:255];
  logic [3:0] save_cnt = 4'h0;
  assign o_dq_drv = !i_bus.chip_on_n && !i_bus.out_drive_n
    && i_bus.write_n;
  assign o_dq = mem[i_bus.addr[7:0]];
  assign o_busy_low = save_cnt != 4'h0;
  // open-drain release reads as the pull-up level
  assign o_int = i_act_high ? i_fire : !i_fire;
  always @(posedge i_clk)
  begin
    if (!i_bus.chip_on_n && !i_bus.write_n)
      mem[i_bus.addr[7:0]] <= i_byte_bus;
    if (save_cnt != 4'h0)
      save_cnt <= save_cnt - 4'h1;
    else if (!i_save_busy_n)
      save_cnt <= 4'hC;
  end
endmodule // nvh_dev_model

//--- dv/testbench.sv
// testbench: host controller against the device model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  import nvh_pkg::*;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, save_req = 1'b0;
  logic act_high = 1'b1, fire = 1'b0, nv_save_busy_n;
  nvh_req_t req = '0;
  nvh_bus_t bus;
  logic ready, rd_valid, busy_seen, int_seen, host_oe_n, sb_out, sb_oe_n;
  logic dq_drv, busy_low, int_pin;
  logic [7:0] rd_data, host_dq, dev_dq, dq, dq_last = 8'h00;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  // an undriven bus shows the inverse of its last level, never a copy
  assign dq = !host_oe_n ? host_dq : dq_drv ? dev_dq : ~dq_last;
  assign nv_save_busy_n = ((!sb_oe_n && !sb_out) || busy_low) ? 1'b0 : 1'b1;
  nvh_host i_nvh_host (.i_clk(clk), .i_sys_rst(rst),
    .i_req_valid(req_valid), .i_req(req), .i_save_req(save_req),
    .i_int_active_high(act_high), .o_req_ready(ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy_seen(busy_seen),
    .o_int_seen(int_seen), .o_bus(bus), .o_byte_bus_out(host_dq),
    .o_byte_bus_oe_n(host_oe_n), .i_byte_bus_in(dq),
    .o_nv_save_busy_n_out(sb_out), .o_nv_save_busy_n_oe_n(sb_oe_n),
    .i_nv_save_busy_n_in(nv_save_busy_n), .i_int_pin(int_pin));
  nvh_dev_model i_nvh_dev_model (.i_clk(clk), .i_bus(bus),
    .i_byte_bus(dq), .i_save_busy_n(nv_save_busy_n), .i_fire(fire),
    .i_act_high(act_high), .o_dq(dev_dq), .o_dq_drv(dq_drv),
    .o_busy_low(busy_low), .o_int(int_pin));
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    dq_last <= dq;
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // valid is held until the ready pulse, as a refused request must be
  task automatic access(input logic wr, rtc, input logic [16:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req = '{wr: wr, rtc: rtc, addr: a, wdata: d};
    req_valid = 1'b1;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b0;
    `CHK("ready", 1'b1, ready)
  endtask
  task automatic t_array();
    access(1'b1, 1'b0, 17'h12345, 8'h3C);
    `CHK("oe_n", 1'b1, host_oe_n)
    access(1'b0, 1'b0, 17'h12345, 8'h00);
    `CHK("addr", 17'h12345, bus.addr)
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", 8'h3C, rd_data)
  endtask
  task automatic t_rtc();
    access(1'b1, 1'b1, 17'h00003, 8'h5A);
    `CHK("rtc_addr", 17'h1FFF3, bus.addr)
    access(1'b0, 1'b1, 17'h00003, 8'h00);
    `CHK("rtc_data", 8'h5A, rd_data)
  endtask
  task automatic t_save();
    int n;
    n = 0;
    @(negedge clk);
    save_req = 1'b1;
    @(negedge clk);
    save_req = 1'b0;
    while (busy_seen !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("busy_seen", 1'b1, busy_seen)
    access(1'b0, 1'b0, 17'h12345, 8'h00);
    `CHK("busy_at_ready", 1'b0, busy_seen)
    `CHK("rd_after_save", 8'h3C, rd_data)
  endtask
  task automatic t_int();
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk);
      act_high = k[1];
      fire = k[0];
      repeat (4) @(negedge clk);
      `CHK("int_seen", k[0], int_seen)
    end
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_array();
    t_rtc();
    t_save();
    t_int();
    end_of_test();
  end
endmodule // testbench
